//--- design/pds_supervisor.sv
// Chosen here: the APB interface to the registers and the register addresses.
module pds_supervisor #(
    parameter int unsigned TICK_CYCLES = pds_pkg::TICK_CYCLES_DEF
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    input  wire pds_pkg::pds_meas_t meas,
    input  wire logic [6:0]        main_fault_pin,
    input  wire logic [4:0]        enc_fault_pin,
    input  wire logic [2:0]        aux_fault_pin,
    output pds_pkg::pds_ctl_t      ctl,
    output logic      [17:0]       fault_cause
);
    import pds_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        pds_pstate_t ps;
        logic [23:0] pre;
        logic        tick;
        logic [31:0] ol_acc;
        logic        oh_flt;
        logic [17:0] cause;
        logic [7:0]  shield;
        logic [7:0]  busopt;
        logic [4:0]  encmask;
        logic [2:0]  shield2;
        logic [15:0] olgain;
        logic [7:0]  olcoef;
        logic [7:0]  tstype;
        logic [7:0]  ohtrip;
        logic [7:0]  ohwarn;
        logic [15:0] ovlevel;
        logic [15:0] oslevel;
        logic [15:0] ostime;
        logic [15:0] rtdecel;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        pds_ctl_t    ctl;
    } pds_sup_st_t;

    pds_sup_st_t s_r;
    pds_sup_st_t s_nxt;

    logic [14:0] pin_sync;
    logic        os_cond;
    logic        os_done;

    // ************************************************************
    // Fault pins come from outside the clock domain
    // ************************************************************
    pds_sync #(
        .W (15)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({aux_fault_pin, enc_fault_pin, main_fault_pin}),
        .q       (pin_sync)
    );

    // Overspeed gate, measurements share this clock
    assign os_cond = (meas.ctrl_mode == MODE_CLOSED_LOOP)
                   && (meas.running || meas.jogging)
                   && (meas.speed_pct > s_r.oslevel);

    // Zero time keeps the timer idle
    pds_qual_timer u_os (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (s_r.tick),
        .cond    (os_cond),
        .limit   (s_r.ostime),
        .done    (os_done)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [31:0] i_x100;
        logic [31:0] knee;
        logic [31:0] rated;
        logic [31:0] budget;
        logic [32:0] sum;
        logic        ol_trip;
        logic        ts_on;
        logic [17:0] raw;
        logic [17:0] live;
        logic        acc_ph;
        logic        wr_now;
        logic        ok;
        logic        hit;
        logic [31:0] rd;
        logic [7:0]  ones;
        logic [7:0]  tens;
        i_x100  = 32'(meas.current_pct) * PCT_SCALE;
        knee    = OL_KNEE * 32'(s_r.olgain);
        rated   = OL_RATED * 32'(s_r.olgain);
        budget  = OL_BUDGET * 32'(s_r.olgain);
        sum     = 33'(s_r.ol_acc) + 33'(i_x100 - knee);
        ol_trip = (s_r.ol_acc >= budget);
        ts_on   = (s_r.tstype >= TSTYPE_MIN)
                && (s_r.tstype <= TSTYPE_MAX);
        acc_ph  = psel && penable;
        wr_now  = acc_ph && s_r.pready && pwrite;
        ok      = 1'b1;
        hit     = 1'b1;
        rd      = 32'h0000_0000;
        ones    = s_r.busopt % DIGIT_BASE;
        tens    = s_r.busopt / DIGIT_BASE;
        s_nxt   = s_r;

        // Tick prescaler sets the time base of all timers
        s_nxt.tick = 1'b0;
        if (s_r.pre == 24'(TICK_CYCLES - 1))
        begin
            s_nxt.pre  = 24'h000000;
            s_nxt.tick = 1'b1;
        end
        else
            s_nxt.pre = s_r.pre + 24'h000001;

        // Inverse-time heat model, linear rate above the knee
        if (s_r.tick)
        begin
            if (i_x100 < rated)
                s_nxt.ol_acc = 32'h0000_0000;
            else if (i_x100 > knee)
                s_nxt.ol_acc = sum[32] ? 32'hffff_ffff
                                       : sum[31:0];
        end

        // Overheat latch; release by a clear below the hysteresis, or at once when the sensor is off
        if (ts_on && meas.temp_deg > s_r.ohtrip)
            s_nxt.oh_flt = 1'b1;
        else if (!ts_on)
            s_nxt.oh_flt = 1'b0;

        // Detected causes, then shield masking
        raw = {os_done, s_r.oh_flt, pin_sync[14:7],
               pin_sync[6:5], ol_trip, pin_sync[4:0]};
        live = raw & ~{2'b00, s_r.shield2, s_r.encmask,
                       s_r.shield};

        // Protection state; a new cause beats a clear
        unique case (s_r.ps)
            PS_RUN:
            begin
                if (live != 18'h00000)
                begin
                    s_nxt.ps    = PS_TRIPPED;
                    s_nxt.cause = live;
                end
            end
            PS_TRIPPED:
            begin
                s_nxt.cause = s_r.cause | live;
                if (wr_now && paddr == OFS_CONTROL && pwdata[0]
                    && live == 18'h00000)
                begin
                    s_nxt.ps    = PS_RUN;
                    s_nxt.cause = 18'h00000;
                end
            end
        endcase
        if (wr_now && paddr == OFS_CONTROL && pwdata[0]
            && ({1'b0, meas.temp_deg} + {1'b0, OH_HYST}
                < {1'b0, s_r.ohtrip}))
            s_nxt.oh_flt = 1'b0;

        // Register read data and range checks
        unique case (paddr)
            OFS_SHIELD:  rd = {24'h0, s_r.shield};
            OFS_BUSOPT:
            begin
                rd = {24'h0, s_r.busopt};
                ok = (pwdata[7:0] % DIGIT_BASE <= RIDE_MAX)
                   && (pwdata[7:0] / DIGIT_BASE <= 8'h01);
            end
            OFS_ENCMASK: rd = {27'h0, s_r.encmask};
            OFS_SHIELD2: rd = {29'h0, s_r.shield2};
            OFS_OLGAIN:
            begin
                rd = {16'h0, s_r.olgain};
                ok = pwdata[15:0] >= OLGAIN_MIN
                   && pwdata[15:0] <= OLGAIN_MAX;
            end
            OFS_OLCOEF:
            begin
                rd = {24'h0, s_r.olcoef};
                ok = pwdata[7:0] >= OLCOEF_MIN
                   && pwdata[7:0] <= OLCOEF_MAX;
            end
            OFS_TSTYPE:
            begin
                rd = {24'h0, s_r.tstype};
                ok = pwdata[7:0] <= TSTYPE_MAX;
            end
            OFS_OHTRIP:
            begin
                rd = {24'h0, s_r.ohtrip};
                ok = pwdata[7:0] <= TEMP_MAX;
            end
            OFS_OHWARN:
            begin
                rd = {24'h0, s_r.ohwarn};
                ok = pwdata[7:0] <= TEMP_MAX;
            end
            OFS_OVLEVEL:
            begin
                rd = {16'h0, s_r.ovlevel};
                ok = pwdata[15:0] >= OVLVL_MIN
                   && pwdata[15:0] <= OVLVL_MAX;
            end
            OFS_OSLEVEL:
            begin
                rd = {16'h0, s_r.oslevel};
                ok = pwdata[15:0] <= OSLVL_MAX;
            end
            OFS_OSTIME:
            begin
                rd = {16'h0, s_r.ostime};
                ok = pwdata[15:0] <= OSTIME_MAX;
            end
            OFS_RTDECEL:
            begin
                rd = {16'h0, s_r.rtdecel};
                ok = pwdata[15:0] <= RTDEC_MAX;
            end
            OFS_STATUS:
            begin
                rd = {29'h0, s_r.ctl.oh_warn, s_r.ctl.ol_prealarm,
                      s_r.ps == PS_TRIPPED};
                ok = !pwrite;
            end
            OFS_CONTROL: rd = 32'h0000_0000;
            OFS_CAUSE:
            begin
                rd = {14'h0, s_r.cause};
                ok = !pwrite;
            end
            default:
            begin
                ok  = 1'b0;
                hit = 1'b0;
            end
        endcase
        // Range checks guard writes only; a read fails only off the map
        if (!pwrite)
            ok = hit;

        // Wait state of one cycle, answer registered
        s_nxt.pready  = acc_ph && !s_r.pready;
        s_nxt.pslverr = acc_ph && !s_r.pready && !ok;
        if (acc_ph && !s_r.pready)
            s_nxt.prdata = pwrite ? 32'h0000_0000 : rd;

        // Writes land only at the completing edge, bad values dropped
        if (wr_now && !s_r.pslverr)
        begin
            unique case (paddr)
                OFS_SHIELD:  s_nxt.shield  = pwdata[7:0];
                OFS_BUSOPT:  s_nxt.busopt  = pwdata[7:0];
                OFS_ENCMASK: s_nxt.encmask = pwdata[4:0];
                OFS_SHIELD2: s_nxt.shield2 = pwdata[2:0];
                OFS_OLGAIN:  s_nxt.olgain  = pwdata[15:0];
                OFS_OLCOEF:  s_nxt.olcoef  = pwdata[7:0];
                OFS_TSTYPE:  s_nxt.tstype  = pwdata[7:0];
                OFS_OHTRIP:  s_nxt.ohtrip  = pwdata[7:0];
                OFS_OHWARN:  s_nxt.ohwarn  = pwdata[7:0];
                OFS_OVLEVEL: s_nxt.ovlevel = pwdata[15:0];
                OFS_OSLEVEL: s_nxt.oslevel = pwdata[15:0];
                OFS_OSTIME:  s_nxt.ostime  = pwdata[15:0];
                OFS_RTDECEL: s_nxt.rtdecel = pwdata[15:0];
                default:     s_nxt.busopt  = s_r.busopt;
            endcase
        end

        // Terminal functions and bus-voltage decode
        s_nxt.ctl.trip = (s_nxt.ps == PS_TRIPPED);
        s_nxt.ctl.ol_prealarm = 40'(s_r.ol_acc) * 40'(PCT_SCALE)
                              > 40'(budget) * 40'(s_r.olcoef);
        s_nxt.ctl.oh_warn = ts_on
                          && meas.temp_deg > s_r.ohwarn;
        s_nxt.ctl.ride_mode = ones[1:0];
        s_nxt.ctl.ov_stall_en = tens[0];
        s_nxt.ctl.uv_stall_en = tens[0];
        s_nxt.ctl.ov_stall_level = s_r.ovlevel;
        s_nxt.ctl.ride_decel_ref = (ones != 8'h00) ? s_r.rtdecel
                                                   : 16'h0000;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r         <= '0;
            s_r.ps      <= PS_RUN;
            s_r.busopt  <= BUSOPT_RST;
            s_r.olgain  <= OLGAIN_RST;
            s_r.olcoef  <= OLCOEF_RST;
            s_r.ohtrip  <= OHTRIP_RST;
            s_r.ohwarn  <= OHWARN_RST;
            s_r.ovlevel <= OVLVL_RST;
            s_r.oslevel <= OSLVL_RST;
            s_r.ostime  <= OSTIME_RST;
            s_r.rtdecel <= RTDEC_RST;
            s_r.ctl.ov_stall_en    <= 1'b1;
            s_r.ctl.uv_stall_en    <= 1'b1;
            s_r.ctl.ov_stall_level <= OVLVL_RST;
        end
        else
            s_r <= s_nxt;
    end

    // Outputs straight from the state register
    assign pready      = s_r.pready;
    assign prdata      = s_r.prdata;
    assign pslverr     = s_r.pslverr;
    assign ctl         = s_r.ctl;
    assign fault_cause = s_r.cause;
endmodule

//--- design/pds_pkg.sv
package pds_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned TICK_MS        = 100;
    localparam int unsigned NS_PER_MS      = 1000000;
    localparam int unsigned TICK_CYCLES_DEF =
        (TICK_MS * NS_PER_MS) / CLK_PERIOD_NS;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_SHIELD   = 8'h00;
    localparam logic [7:0] OFS_BUSOPT   = 8'h04;
    localparam logic [7:0] OFS_ENCMASK  = 8'h08;
    localparam logic [7:0] OFS_SHIELD2  = 8'h0c;
    localparam logic [7:0] OFS_OLGAIN   = 8'h10;
    localparam logic [7:0] OFS_OLCOEF   = 8'h14;
    localparam logic [7:0] OFS_TSTYPE   = 8'h18;
    localparam logic [7:0] OFS_OHTRIP   = 8'h1c;
    localparam logic [7:0] OFS_OHWARN   = 8'h20;
    localparam logic [7:0] OFS_OVLEVEL  = 8'h24;
    localparam logic [7:0] OFS_OSLEVEL  = 8'h28;
    localparam logic [7:0] OFS_OSTIME   = 8'h2c;
    localparam logic [7:0] OFS_RTDECEL  = 8'h30;
    localparam logic [7:0] OFS_STATUS   = 8'h34;
    localparam logic [7:0] OFS_CONTROL  = 8'h38;
    localparam logic [7:0] OFS_CAUSE    = 8'h3c;

    // ************************************************************
    // Reset values and legal ranges
    // ************************************************************
    localparam logic [15:0] OLGAIN_RST = 16'h0064;  // 1.00
    localparam logic [15:0] OLGAIN_MIN = 16'h0014;  // 0.20
    localparam logic [15:0] OLGAIN_MAX = 16'h03e8;  // 10.00
    localparam logic [7:0]  OLCOEF_RST = 8'h50;     // 80 %
    localparam logic [7:0]  OLCOEF_MIN = 8'h32;
    localparam logic [7:0]  OLCOEF_MAX = 8'h64;
    localparam logic [7:0]  BUSOPT_RST = 8'h0a;     // decimal 10
    localparam logic [7:0]  DIGIT_BASE = 8'h0a;
    localparam logic [7:0]  RIDE_MAX   = 8'h02;
    localparam logic [7:0]  TSTYPE_MIN = 8'h02;
    localparam logic [7:0]  TSTYPE_MAX = 8'h04;
    localparam logic [7:0]  OHTRIP_RST = 8'h6e;     // 110 C
    localparam logic [7:0]  OHWARN_RST = 8'h5a;     // 90 C
    localparam logic [7:0]  TEMP_MAX   = 8'hc8;     // 200 C
    localparam logic [7:0]  OH_HYST    = 8'h14;     // 20 C below trip
    localparam logic [15:0] OVLVL_RST  = 16'h053d;  // 134.1 %
    localparam logic [15:0] OVLVL_MIN  = 16'h044c;  // 110.0 %
    localparam logic [15:0] OVLVL_MAX  = 16'h05dc;  // 150.0 %
    localparam logic [15:0] OSLVL_RST  = 16'h00c8;  // 20.0 %
    localparam logic [15:0] OSLVL_MAX  = 16'h01f4;  // 50.0 %
    localparam logic [15:0] OSTIME_RST = 16'h000a;  // 1.0 s
    localparam logic [15:0] OSTIME_MAX = 16'h0258;  // 60.0 s
    localparam logic [15:0] RTDEC_RST  = 16'h07d0;  // 20.00 s
    localparam logic [15:0] RTDEC_MAX  = 16'h7530;  // 300.00 s
    localparam logic [7:0]  MODE_CLOSED_LOOP = 8'h02;

    // ************************************************************
    // Overload inverse-time model, current in tenths of a percent
    // ************************************************************
    localparam logic [31:0] OL_RATED  = 32'd1000;   // 100.0 %
    localparam logic [31:0] OL_KNEE   = 32'd1464;   // zero-heat point
    localparam logic [31:0] OL_BUDGET = 32'd321600; // per unit gain
    localparam logic [31:0] PCT_SCALE = 32'd100;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [15:0] current_pct;  // tenths of % of rated current
        logic [7:0]  temp_deg;
        logic [15:0] speed_pct;    // tenths of % of max frequency
        logic [7:0]  ctrl_mode;
        logic        running;
        logic        jogging;
    } pds_meas_t;

    typedef struct packed {
        logic        trip;
        logic        ol_prealarm;
        logic        oh_warn;
        logic [1:0]  ride_mode;
        logic        ov_stall_en;
        logic        uv_stall_en;
        logic [15:0] ov_stall_level;
        logic [15:0] ride_decel_ref;
    } pds_ctl_t;

    typedef enum logic {
        PS_RUN     = 1'b0,
        PS_TRIPPED = 1'b1
    } pds_pstate_t;

endpackage

//--- design/pds_sync.sv
module pds_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pds_sync_st_t;

    pds_sync_st_t s_r;
    pds_sync_st_t s_nxt;

    // Two stages; only the second stage is visible
    always_comb
    begin
        s_nxt    = s_r;
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign q = s_r.s2;
endmodule

//--- design/pds_qual_timer.sv
module pds_qual_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        tick,
    input  wire logic        cond,
    input  wire logic [15:0] limit,
    output logic             done
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        done;
    } pds_qt_st_t;

    pds_qt_st_t s_r;
    pds_qt_st_t s_nxt;

    // Count ticks while the condition holds; any gap restarts
    always_comb
    begin
        s_nxt = s_r;
        if (!cond || limit == 16'h0000)
        begin
            s_nxt.cnt  = 16'h0000;
            s_nxt.done = 1'b0;
        end
        else if (s_r.cnt >= limit)
            s_nxt.done = 1'b1;
        else if (tick)
            s_nxt.cnt = s_r.cnt + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign done = s_r.done;
endmodule

//--- tb/pds_plant_model.sv
module pds_plant_model (
    input  wire pds_pkg::pds_meas_t want,
    input  wire logic [14:0]        want_pins,
    output pds_pkg::pds_meas_t      meas,
    output logic      [14:0]        pins
    ,input wire logic               pclk
);
    import pds_pkg::*;
    // ********
    // Motor, sensor and encoder
    // ********
    // One sample of lag, as a real sensor front end has
    always_ff @(posedge pclk)
    begin
        meas <= want;
        pins <= want_pins;
    end
endmodule

//--- tb/pds_supervisor_asserts.sv
module pds_supervisor_asserts
    import pds_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire pds_pkg::pds_meas_t meas,
    input wire pds_pkg::pds_ctl_t  ctl,
    input wire logic [17:0]        fault_cause
);
    // ********
    // Port checks
    // ********
    // Single domain, so clock and reset are stated once
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_done; psel && penable && pready; endsequence
    property p_ready_wait; s_wait |=> s_done; endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("no answer after one wait");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    // A fresh cause must come with the halt
    property p_trip_cause; $rose(|fault_cause) |-> ctl.trip; endproperty
    a_trip_cause: assert property (p_trip_cause)
        else $error("cause without trip");
    // Only a committed clear write may lift the halt
    property p_trip_fall; $fell(ctl.trip) |->
        $past(psel) && $past(penable) && $past(pready) && $past(pwrite)
        && $past(paddr) == OFS_CONTROL;
    endproperty
    a_trip_fall: assert property (p_trip_fall)
        else $error("trip dropped without clear");
    property p_uv_ov; ctl.uv_stall_en == ctl.ov_stall_en; endproperty
    a_uv_ov: assert property (p_uv_ov)
        else $error("stall enables differ");
    property p_ride_ref; ctl.ride_mode == 2'd0 |-> ctl.ride_decel_ref == 0;
    endproperty
    a_ride_ref: assert property (p_ride_ref)
        else $error("decel ref with ride off");
    property p_ov_lvl; ctl.ov_stall_level inside {[OVLVL_MIN:OVLVL_MAX]};
    endproperty
    a_ov_lvl: assert property (p_ov_lvl)
        else $error("stall level out of range");
    property p_os_mode; $rose(fault_cause[17]) |->
        $past(meas.ctrl_mode, 2) == MODE_CLOSED_LOOP
        && ($past(meas.running, 2) || $past(meas.jogging, 2));
    endproperty
    a_os_mode: assert property (p_os_mode)
        else $error("overspeed outside closed loop run");
endmodule

bind pds_supervisor pds_supervisor_asserts #(
    .TICK_CYCLES(TICK_CYCLES)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .meas(meas), .ctl(ctl), .fault_cause(fault_cause)
);

//--- tb/pds_supervisor_test.sv
module pds_supervisor_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pds_pkg::*;
    localparam int TK = 4;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [31:0] rv;
    logic        re;
    pds_meas_t   want = '0;
    pds_meas_t   meas;
    logic [14:0] want_pins = 15'h0;
    logic [14:0] pins;
    pds_ctl_t    ctl;
    logic [17:0] fault_cause;
    int          err_total = 0;
    int          checks_done = 0;
    // ********
    // Harness
    // ********
    always #4 pclk = ~pclk;
    pds_plant_model u_plant (.pclk(pclk), .want(want),
        .want_pins(want_pins), .meas(meas), .pins(pins));
    // Short tick keeps the long overload curve inside the run
    pds_supervisor #(.TICK_CYCLES(TK)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .meas(meas),
        .main_fault_pin(pins[6:0]), .enc_fault_pin(pins[11:7]),
        .aux_fault_pin(pins[14:12]), .ctl(ctl), .fault_cause(fault_cause));
    task automatic close_out();
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait on ready, prealarm or trip
    task automatic wt(input int s, input int lim, output int n);
        for (n = 0; n < lim; n++)
        begin
            @(negedge pclk);
            if ((s == 0 ? pready : s == 1 ? ctl.ol_prealarm : ctl.trip))
                return;
        end
        err_total++;
        close_out();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer is taken at the very edge that completes the access
        for (n = 0; n < 20 && !pready; n++)
            @(posedge pclk);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!pready)
        begin
            err_total++;
            close_out();
        end
    endtask
    task automatic clear();
        apb(1'b1, OFS_CONTROL, 1);
        @(negedge pclk);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_regs();
        int rst [13] = '{0, 10, 0, 0, 100, 80, 0, 110, 90, 1341, 200, 10, 2000};
        for (int i = 0; i < 13; i++)
        begin
            apb(1'b0, 8'(4 * i), 0);
            chk(rv, rst[i], "reset value");
        end
        apb(1'b0, 8'h40, 0);
        chk(32'(re), 32'h1, "unmapped");
        apb(1'b1, OFS_OLGAIN, 19);
        apb(1'b0, OFS_OLGAIN, 0);
        chk(rv, 32'h64, "gain kept");
        apb(1'b1, OFS_OVLEVEL, 1501);
        chk(32'(re), 32'h1, "level refused");
        apb(1'b1, OFS_OVLEVEL, 1200);
        repeat (2) @(negedge pclk);
        chk(32'(ctl.ov_stall_level), 1200, "stall level");
    endtask
    task automatic t_busopt();
        int v [6] = '{0, 1, 2, 10, 11, 12};
        foreach (v[i])
        begin
            apb(1'b1, OFS_BUSOPT, v[i]);
            repeat (2) @(negedge pclk);
            chk(32'(ctl.ride_mode), v[i] % 10, "ride");
            chk(32'(ctl.ov_stall_en), v[i] > 9, "ov stall");
            chk(32'(ctl.uv_stall_en), v[i] > 9, "uv stall");
            chk(32'(ctl.ride_decel_ref), v[i] % 10 ? 2000 : 0, "ref");
        end
    endtask
    task automatic t_fault(input int p, input logic s);
        int c = p < 5 ? p : p + 1;
        logic [7:0] a = p < 7 ? OFS_SHIELD : p < 12 ? OFS_ENCMASK : OFS_SHIELD2;
        apb(1'b1, a, int'(s) << (p < 7 ? c : p < 12 ? p - 7 : p - 12));
        want_pins[p] <= 1'b1;
        repeat (6) @(negedge pclk);
        chk(32'({ctl.trip, fault_cause[c]}), s ? 0 : 3, "trip");
        clear();
        chk(32'(ctl.trip), 32'(!s), "held");
        want_pins[p] <= 1'b0;
        repeat (4) @(negedge pclk);
        clear();
        apb(1'b1, a, 0);
    endtask
    task automatic t_heat();
        want.temp_deg <= 8'd150;
        repeat (6) @(negedge pclk);
        chk(32'({ctl.oh_warn, ctl.trip}), 0, "sensor off");
        want.temp_deg <= 8'd95;
        for (int k = 2; k < 5; k++)
        begin
            apb(1'b1, OFS_TSTYPE, k);
            repeat (4) @(negedge pclk);
            chk(32'({ctl.oh_warn, ctl.trip}), 2, "warn");
        end
        want.temp_deg <= 8'd111;
        repeat (6) @(negedge pclk);
        chk(32'({ctl.trip, fault_cause[16]}), 3, "hot");
        want.temp_deg <= 8'd95;
        clear();
        chk(32'(ctl.trip), 1, "hot held");
        want.temp_deg <= 8'd80;
        // One clear releases the cooled latch, the next the halt
        clear();
        clear();
        chk(32'(ctl.trip), 0, "cooled");
    endtask
    task automatic t_speed();
        int n;
        apb(1'b1, OFS_OSTIME, 0);
        want.speed_pct <= 16'd300;
        want.ctrl_mode <= MODE_CLOSED_LOOP;
        want.running <= 1'b1;
        repeat (40) @(negedge pclk);
        chk(32'(ctl.trip), 0, "os off");
        want.ctrl_mode <= 8'h00;
        apb(1'b1, OFS_OSTIME, 2);
        repeat (40) @(negedge pclk);
        chk(32'(ctl.trip), 0, "os mode");
        want.ctrl_mode <= MODE_CLOSED_LOOP;
        want.running <= 1'b0;
        want.jogging <= 1'b1;
        wt(2, 40, n);
        chk(32'(n >= TK && fault_cause[17]), 1, "os trip");
        want.speed_pct <= 16'd0;
        clear();
    endtask
    // Second run only times right if the first one's heat was dropped
    task automatic t_load(input int cur, input int tt);
        int n1;
        int n2;
        int tp = tt * OLCOEF_RST / 100;
        int tol = tt / 100 + 2;
        want.running <= 1'b1;
        want.current_pct <= 16'(cur);
        wt(1, 40000, n1);
        wt(2, 40000, n2);
        n2 = (n1 + n2) / TK;
        n1 = n1 / TK;
        chk(32'(n1 >= tp - tol && n1 <= tp + tol), 1, "prealarm");
        chk(32'(n2 >= tt - tol && n2 <= tt + tol), 1, "ol");
        want.current_pct <= 16'd0;
        repeat (3 * TK) @(negedge pclk);
        clear();
        chk(32'({ctl.trip, ctl.ol_prealarm}), 0, "ol cleared");
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_busopt();
        for (int p = 0; p < 15; p++)
        begin
            t_fault(p, 1'b1);
            t_fault(p, 1'b0);
        end
        t_heat();
        t_speed();
        t_load(1500, 9000);
        t_load(2000, 600);
        close_out();
    end
endmodule
